// file: hdl/sarseq_fifo.sv
// result fifo with parameter width and depth
`default_nettype none
module sarseq_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    // clock and reset
    input  wire logic   core_clk_i,
    input  wire logic   sys_rst_i,
    // stream
    sarseq_fifo_if.fifo f
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = f.in_valid && f.in_ready;
    wire              pop  = f.out_valid && f.out_ready;
    assign f.full      = (cnt_q == (AW+1)'(DEPTH));
    assign f.empty     = (cnt_q == '0);
    assign f.in_ready  = !f.full;
    assign f.out_valid = !f.empty;
    assign f.out_data  = mem[rd_q];
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_q] <= f.in_data;
        end
    end
    // pointers wrap naturally only for power-of-two depth
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= push ? wr_q + 1'b1 : wr_q;
            rd_q  <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sarseq_fifo
`default_nettype wire

// file: hdl/sarseq_fifo_if.sv
// stream carrier between sequencer and result fifo
`default_nettype none
interface sarseq_fifo_if #(parameter int unsigned WIDTH = 16);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;
    logic             full;
    logic             empty;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, full, empty);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, full, empty);
endinterface : sarseq_fifo_if
`default_nettype wire

// file: hdl/sarseq_pkg.sv
// constants, types and contract list of the conversion sequencer
// Contract
// - falling start after acquisition begins conversion
// - conversion start isolates arrays onto reference ground
// - sixteen bit decisions, msb first
// - decisions done: output code, busy low
// - result belongs to same conversion, no latency
// - fastest mode reaches one msps; here fast starts are at least 24 cycles apart (about 833 ksps)
// - normal mode reaches 800 ksps, no interval limit
// - low-power mode saves power, 666 ksps
// - coding select picks binary or two's complement
// - low-power when low-power high, fast low
// - low-power: start held low restarts immediately; here the restart waits for the 30-cycle start spacing
// - power-down finishes current then blocks conversions
// - running conversion never restarted nor aborted
`default_nettype none
package sarseq_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned ACQ_NS          = 300;
    localparam int unsigned ACQ_CYC         = (ACQ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned WARP_SPS        = 1_000_000;
    localparam int unsigned NORM_SPS        = 800_000;
    localparam int unsigned LOWP_SPS        = 666_000;
    localparam int unsigned WARP_PERIOD_CYC = CLK_HZ / WARP_SPS;
    localparam int unsigned NORM_PERIOD_CYC = CLK_HZ / NORM_SPS;
    localparam int unsigned LOWP_PERIOD_CYC = CLK_HZ / LOWP_SPS;
    localparam int unsigned RES_BITS        = 16;
    localparam int unsigned FIFO_DEPTH      = 16;
    // ------------------------------------------------------------
    // wishbone map (word addresses are byte offsets / 4)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_SAMPLE = 8'h0C;
    // ctrl fields
    localparam int unsigned CTRL_START_N = 0;
    localparam int unsigned CTRL_CODING  = 1;
    localparam int unsigned CTRL_LOWP    = 2;
    localparam int unsigned CTRL_FAST    = 3;
    localparam int unsigned CTRL_PDOWN   = 4;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
    // status fields
    localparam int unsigned ST_BUSY    = 0;
    localparam int unsigned ST_HOLD    = 1;
    localparam int unsigned ST_LOWPWR  = 2;
    localparam int unsigned ST_FEMPTY  = 3;
    localparam int unsigned ST_FFULL   = 4;
    localparam int unsigned ST_OVF     = 5;
    localparam int unsigned ST_MODE_LO = 6;
    typedef enum logic [1:0] {SARSEQ_NORMAL, SARSEQ_FAST, SARSEQ_LOWP} sarseq_mode_t;
    typedef enum {SARSEQ_ACQ, SARSEQ_CONV, SARSEQ_DONE} sarseq_state_t;
endpackage : sarseq_pkg
`default_nettype wire

// file: hdl/sarseq_top.sv
// successive-approximation conversion sequencer with wishbone slave
`default_nettype none
module sarseq_top
    import sarseq_pkg::*;
#(
    parameter int unsigned ACQ_CYCLES = sarseq_pkg::ACQ_CYC
) (
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       sys_rst_i,
    // wishbone slave
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [7:0]                 wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    // converter pins
    input  wire logic                       conversion_start_n_i,
    input  wire logic                       comparator_i,
    output logic                            busy_o,
    output logic                            sample_hold_o,
    output logic                            reference_ground_o,
    output logic [sarseq_pkg::RES_BITS-1:0] dac_code_o,
    output logic [sarseq_pkg::RES_BITS-1:0] result_o,
    output logic                            low_power_o
);
    import sarseq_pkg::*;
    // ------------------------------------------------------------
    // registers and wires
    // ------------------------------------------------------------
    sarseq_state_t         state_q;
    logic [31:0]           ctrl_q;
    logic [RES_BITS-1:0]   trial_q;
    logic [RES_BITS-1:0]   bit_q;
    logic [7:0]            acq_cnt_q;
    logic [7:0]            rate_cnt_q;
    logic                  start_n_q;
    logic                  ovf_q;
    logic [RES_BITS-1:0]   code_q;
    sarseq_fifo_if #(.WIDTH(RES_BITS)) fq ();
    sarseq_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .f          (fq)
    );
    // effective start: pin and software bit are anded (both active low)
    wire start_n  = conversion_start_n_i & ctrl_q[CTRL_START_N];
    wire fast_pin = ctrl_q[CTRL_FAST];
    wire lowp_pin = ctrl_q[CTRL_LOWP];
    wire pdown    = ctrl_q[CTRL_PDOWN];
    wire sarseq_mode_t mode = fast_pin ? SARSEQ_FAST : (lowp_pin ? SARSEQ_LOWP : SARSEQ_NORMAL);
    // start spacing per mode: 20, 25, 30 cycles
    function automatic logic [7:0] period_of(input sarseq_mode_t m);
        case (m)
            SARSEQ_FAST: period_of = 8'(WARP_PERIOD_CYC);
            SARSEQ_LOWP: period_of = 8'(LOWP_PERIOD_CYC);
            default:     period_of = 8'(NORM_PERIOD_CYC);
        endcase
    endfunction : period_of
    wire acq_done  = (acq_cnt_q >= 8'(ACQ_CYCLES)) && (rate_cnt_q >= period_of(mode));
    wire fall      = start_n_q && !start_n;
    wire auto_go   = (mode == SARSEQ_LOWP) && !start_n;
    // begin on falling start after acquisition; none while powered down
    wire go        = (state_q == SARSEQ_ACQ) && acq_done && !pdown && (fall || auto_go);
    wire last_bit  = bit_q[0];
    // keep or drop trial bit, then try the next lower one
    wire [RES_BITS-1:0] kept  = comparator_i ? trial_q : (trial_q & ~bit_q);
    wire [RES_BITS-1:0] nxt   = kept | (bit_q >> 1);
    // coding select; array code is straight binary, two's complement flips its msb
    wire [RES_BITS-1:0] coded = ctrl_q[CTRL_CODING] ? {~kept[RES_BITS-1], kept[RES_BITS-2:0]} : kept;
    wire wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_ctrl  = wb_req && wb_we_i && (wb_adr_i == REG_CTRL);
    wire rd_data  = wb_req && !wb_we_i && (wb_adr_i == REG_DATA);
    assign fq.in_valid  = (state_q == SARSEQ_CONV) && last_bit;
    assign fq.in_data   = coded;
    assign fq.out_ready = rd_data;
    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // no abort path: conversion leaves only after the last bit
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q    <= SARSEQ_ACQ;
            trial_q    <= '0;
            bit_q      <= '0;
            acq_cnt_q  <= '0;
            rate_cnt_q <= '0;
            start_n_q  <= 1'b1;
            code_q     <= '0;
            ovf_q      <= 1'b0;
        end else begin
            start_n_q  <= start_n;
            rate_cnt_q <= (rate_cnt_q == 8'hFF) ? rate_cnt_q : rate_cnt_q + 8'h01;
            case (state_q)
                SARSEQ_ACQ: begin
                    acq_cnt_q <= (acq_cnt_q == 8'hFF) ? acq_cnt_q : acq_cnt_q + 8'h01;
                    if (go) begin
                        state_q    <= SARSEQ_CONV;
                        trial_q    <= {1'b1, {(RES_BITS-1){1'b0}}};
                        bit_q      <= {1'b1, {(RES_BITS-1){1'b0}}};
                        rate_cnt_q <= 8'h01;
                    end
                end
                SARSEQ_CONV: begin
                    trial_q <= nxt;
                    bit_q   <= bit_q >> 1;
                    if (last_bit) begin
                        code_q  <= coded;
                        ovf_q   <= ovf_q | !fq.in_ready;
                        state_q <= SARSEQ_DONE;
                    end
                end
                SARSEQ_DONE: begin
                    acq_cnt_q <= '0;
                    state_q   <= SARSEQ_ACQ;
                end
                default: state_q <= SARSEQ_ACQ;
            endcase
            if (wb_req && wb_we_i && wb_adr_i == REG_STATUS && wb_dat_i[ST_OVF] && !(fq.in_valid && !fq.in_ready)) begin
                ovf_q <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // pin outputs from flops
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_o             <= 1'b0;
            sample_hold_o      <= 1'b0;
            reference_ground_o <= 1'b0;
            dac_code_o         <= '0;
            result_o           <= '0;
            low_power_o        <= 1'b0;
        end else begin
            busy_o             <= go || (state_q == SARSEQ_CONV && !last_bit);
            // hold sample, arrays onto reference ground
            sample_hold_o      <= go || (state_q == SARSEQ_CONV && !last_bit);
            reference_ground_o <= go || (state_q == SARSEQ_CONV && !last_bit);
            dac_code_o         <= go ? {1'b1, {(RES_BITS-1){1'b0}}} : nxt;
            result_o           <= (state_q == SARSEQ_CONV && last_bit) ? coded : result_o;
            // power saved between low-power conversions; and while powered down
            low_power_o        <= (state_q != SARSEQ_CONV && !go) && (pdown || mode == SARSEQ_LOWP);
        end
    end
    // ------------------------------------------------------------
    // wishbone slave, one wait state
    // ------------------------------------------------------------
    wire [31:0] status_w = {24'h00_0000, mode, ovf_q, fq.full, fq.empty,
                            low_power_o, sample_hold_o, busy_o};
    wire [31:0] rd_mux   = (wb_adr_i == REG_CTRL)   ? ctrl_q :
                           (wb_adr_i == REG_STATUS) ? status_w :
                           (wb_adr_i == REG_DATA)   ? {16'h0000, fq.out_data} :
                           (wb_adr_i == REG_SAMPLE) ? {16'h0000, code_q} : 32'h0000_0000;
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_q   <= CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
            if (wr_ctrl && wb_sel_i[0]) begin
                ctrl_q <= {27'h000_0000, wb_dat_i[4:0]};
            end
        end
    end
endmodule : sarseq_top
`default_nettype wire

// file: tb/sarseq_front_model.sv
// analog front end model that answers the comparator from a target code
`default_nettype none
module sarseq_front_model (
    // trial code from the sequencer, target from the bench
    input  wire logic [15:0] dac_code_i,
    input  wire logic [15:0] level_i,
    // decision back to the sequencer
    output logic             comparator_o
);
    // keep trial bit
    // trial not above the held sample keeps the bit, so the result settles on the target
    assign comparator_o = (dac_code_i <= level_i);
endmodule : sarseq_front_model
`default_nettype wire

// file: tb/sarseq_properties.sv
// port checker of the conversion sequencer
`default_nettype none
module sarseq_properties
    import sarseq_pkg::*;
#(
    parameter int unsigned ACQ_CYCLES = sarseq_pkg::ACQ_CYC
) (
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        sys_rst_i,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // converter pins
    input wire logic        conversion_start_n_i,
    input wire logic        comparator_i,
    input wire logic        busy_o,
    input wire logic        sample_hold_o,
    input wire logic        reference_ground_o,
    input wire logic [15:0] dac_code_o,
    input wire logic [15:0] result_o,
    input wire logic        low_power_o
);
    import sarseq_pkg::*;
    // counts busy cycles so the decision count can be checked without long repetitions
    logic [4:0] busy_cnt_q;
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            busy_cnt_q <= 5'h0;
        else
            busy_cnt_q <= busy_o ? busy_cnt_q + 5'h1 : 5'h0;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_conv_begin;
        $rose(busy_o);
    endsequence
    chk_ack_one_wait: assert property (s_req |=> wb_ack_o) else $error("ack not one cycle after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    chk_read_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");
    chk_msb_trial_first: assert property (s_conv_begin |-> dac_code_o == 16'h8000)
        else $error("first trial not msb");
    chk_hold_with_busy: assert property (sample_hold_o == busy_o && reference_ground_o == busy_o)
        else $error("hold or ground not with busy");
    chk_sixteen_decisions: assert property ($fell(busy_o) |-> busy_cnt_q == 5'h10)
        else $error("busy not 16 cycles");
    chk_no_abort: assert property (busy_o && busy_cnt_q < 5'hf |=> busy_o)
        else $error("conversion cut short");
    chk_result_at_end: assert property ($changed(result_o) |-> $fell(busy_o))
        else $error("result moved mid run");
    chk_idle_low_power: assert property (low_power_o |-> !busy_o)
        else $error("low power while busy");
endmodule : sarseq_properties
bind sarseq_top sarseq_properties #(.ACQ_CYCLES(ACQ_CYCLES)) sarseq_properties_i (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .conversion_start_n_i(conversion_start_n_i), .comparator_i(comparator_i),
    .busy_o(busy_o), .sample_hold_o(sample_hold_o), .reference_ground_o(reference_ground_o),
    .dac_code_o(dac_code_o), .result_o(result_o), .low_power_o(low_power_o));
`default_nettype wire

// file: tb/sarseq_top_test.sv
// self-checking bench of the conversion sequencer
`default_nettype none
module sarseq_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sarseq_pkg::*;
    logic        core_clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, conversion_start_n_i;
    logic        comparator_i, busy_o, sample_hold_o, reference_ground_o, low_power_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] dac_code_o, result_o, level;
    int          fails, compares;
    logic [4:0]  ctrl_tab [5] = '{5'h01, 5'h03, 5'h09, 5'h05, 5'h0D};
    logic [7:0]  st_tab [5] = '{8'h08, 8'h08, 8'h48, 8'h8C, 8'h48};
    logic [15:0] lvl_tab [4] = '{16'h0000, 16'hFFFF, 16'h7FFF, 16'h1234};
    sarseq_top sarseq_top_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conversion_start_n_i(conversion_start_n_i),
        .comparator_i(comparator_i), .busy_o(busy_o), .sample_hold_o(sample_hold_o),
        .reference_ground_o(reference_ground_o), .dac_code_o(dac_code_o), .result_o(result_o),
        .low_power_o(low_power_o));
    sarseq_front_model sarseq_front_model_i (.dac_code_i(dac_code_o), .level_i(level), .comparator_o(comparator_i));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one classic cycle; a missing ack is cut off by the bound and counted
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge core_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        check("ack", 32'h0000_0001, {31'h0, n < 20});
    endtask : wb_cycle
    // go tells whether the start pulse must be taken; a missed start or a stuck busy is counted
    task automatic convert(input logic [15:0] lvl, input logic [15:0] exp, input logic pd, input logic go);
        int n;
        level <= lvl;
        repeat (40) @(posedge core_clk_i);
        conversion_start_n_i <= 1'b0;
        @(posedge core_clk_i);
        conversion_start_n_i <= 1'b1;
        if (pd) begin
            wb_cycle(1'b1, REG_CTRL, 32'h0000_0011);
        end
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (busy_o !== 1'b1 && n < 5);
        check("start", {31'h0, go}, {31'h0, busy_o});
        do begin
            @(posedge core_clk_i);
            n++;
        end while (busy_o !== 1'b0 && n < 40);
        check("idle", 32'h0, {31'h0, busy_o});
        check("result", {16'h0, exp}, {16'h0, result_o});
    endtask : convert
    // start held low in low-power mode must chain a second conversion without a new edge
    task automatic held_start(input logic [15:0] lvl);
        int n;
        level <= lvl;
        conversion_start_n_i <= 1'b0;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (busy_o !== 1'b1 && n < 100);
        do begin
            @(posedge core_clk_i);
            n++;
        end while (busy_o !== 1'b0 && n < 100);
        do begin
            @(posedge core_clk_i);
            n++;
        end while (busy_o !== 1'b1 && n < 100);
        conversion_start_n_i <= 1'b1;
        check("restart", 32'h0000_0001, {31'h0, n < 100});
        do begin
            @(posedge core_clk_i);
            n++;
        end while (busy_o !== 1'b0 && n < 140);
        check("result", {16'h0, lvl}, {16'h0, result_o});
    endtask : held_start
    task automatic wrap_up();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    initial begin
        #1ms;
        fails++;
        wrap_up();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        conversion_start_n_i = 1'b1;
        level = 16'h0;
        fails = 0;
        compares = 0;
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        wb_cycle(1'b0, REG_CTRL, 32'h0);
        check("ctrl", CTRL_RESET, rd);
        wb_cycle(1'b0, REG_STATUS, 32'h0);
        check("status", 32'h0000_0008, rd);
        wb_cycle(1'b1, 8'h10, 32'hFFFF_FFFF);
        wb_cycle(1'b0, 8'h10, 32'h0);
        check("unmapped", 32'h0, rd);
        // fast-mode starts stay a few microseconds apart, far inside 1 ms, so every fast result is compared
        // host pacing
        for (int m = 0; m < 5; m++) begin
            wb_cycle(1'b1, REG_CTRL, {27'h0, ctrl_tab[m]});
            for (int k = 0; k < 4; k++) begin
                convert(lvl_tab[k], lvl_tab[k] ^ {ctrl_tab[m][1], 15'h0}, 1'b0, 1'b1);
                wb_cycle(1'b0, REG_DATA, 32'h0);
                check("data", {16'h0, lvl_tab[k] ^ {ctrl_tab[m][1], 15'h0}}, rd);
            end
            wb_cycle(1'b0, REG_STATUS, 32'h0);
            check("mode", {24'h0, st_tab[m]}, rd);
        end
        wb_cycle(1'b0, REG_SAMPLE, 32'h0);
        check("sample", 32'h0000_1234, rd);
        wb_cycle(1'b1, REG_CTRL, 32'h0000_0001);
        convert(16'h00A5, 16'h00A5, 1'b1, 1'b1);
        wb_cycle(1'b0, REG_DATA, 32'h0);
        check("data", 32'h0000_00A5, rd);
        convert(16'h5A5A, 16'h00A5, 1'b0, 1'b0);
        wb_cycle(1'b0, REG_STATUS, 32'h0);
        check("pdown", 32'h0000_000C, rd);
        wb_cycle(1'b1, REG_CTRL, 32'h0000_0001);
        for (int i = 0; i < 17; i++) convert(i[15:0], i[15:0], 1'b0, 1'b1);
        wb_cycle(1'b0, REG_STATUS, 32'h0);
        check("full", 32'h0000_0030, rd);
        for (int i = 0; i < 16; i++) begin
            wb_cycle(1'b0, REG_DATA, 32'h0);
            check("drain", i, rd);
        end
        wb_cycle(1'b0, REG_STATUS, 32'h0);
        check("empty", 32'h0000_0028, rd);
        wb_cycle(1'b1, REG_STATUS, 32'h0000_0020);
        wb_cycle(1'b0, REG_STATUS, 32'h0);
        check("clear", 32'h0000_0008, rd);
        wb_cycle(1'b1, REG_CTRL, 32'h0000_0005);
        held_start(16'h4321);
        wrap_up();
    end
endmodule : sarseq_top_test
`default_nettype wire
